// *** include/branch_unit_pkg.sv ***
// Function
// - Repeat flag on loads target, else next
// - Sign digit equals comparison digit then branch
// - Variation zero branches only on high
// - Variation one branches only on low
// - Variations other than one mean high
// - Variation zero branches only on equal
// - Variation one branches on high or low
// - Variations other than one mean equal
// - Branches never alter comparison or repeat flags
// - No comparison result: alarm, advance, clear operand
// - Field digits match alternating basis digits, branch
// - Extension field branch mirrors accumulator field branch
// - Position picks low digit, length counts digits
// - Residual length after compare flags field overflow
// - Overflow still loads target or next address
// - Registers unchanged, operand address always cleared
// - Odd sign digit selects index modification
// - Field branch timing 90 fetch, 75/95 execute
package branch_unit_pkg;

  // ****************************************************************
  // Word and instruction layout
  // ****************************************************************
  localparam int WORD_W   = 44;             // Sign plus ten digits
  localparam int ADDR_W   = 16;             // Four decimal digits
  localparam int CNT_W    = 17;             // Timing counter width
  localparam logic [3:0] LAST_POS = 4'hA;   // Rightmost digit position
  localparam logic [3:0] FULL_LEN = 4'hA;   // Length digit zero means ten

  typedef logic [WORD_W-1:0] word_t;        // Sign digit in top nibble

  typedef struct packed {
    logic [3:0]        sign_digit;          // Odd: index modification
    logic [3:0]        pos_digit;           // Field position
    logic [3:0]        len_digit;           // Field length
    logic [3:0]        basis_hi;            // High digit of basis
    logic [3:0]        basis_lo;            // Low digit, variation, n
    logic [7:0]        opcode;              // Two decimal digits
    logic [ADDR_W-1:0] address;             // Target address field
  } instr_t;

  typedef struct packed {
    logic [ADDR_W-1:0] next_pc;             // Value for program counter
    logic              taken;               // Branch occurred
    logic              alarm_no_compare;    // No comparison result
    logic              alarm_field_overflow;// Field overflow
  } branch_result_t;

  // ****************************************************************
  // Operation codes and comparison flag codes
  // ****************************************************************
  localparam logic [7:0] OP_REPEAT  = 8'h32;
  localparam logic [7:0] OP_SIGN    = 8'h33;
  localparam logic [7:0] OP_HIGHLOW = 8'h34;
  localparam logic [7:0] OP_EQUAL   = 8'h35;
  localparam logic [7:0] OP_FIELD_A = 8'h36;
  localparam logic [7:0] OP_FIELD_R = 8'h37;
  localparam logic [3:0] VAR_ONE    = 4'h1;

  localparam logic [1:0] CMP_NONE  = 2'h0;
  localparam logic [1:0] CMP_HIGH  = 2'h1;
  localparam logic [1:0] CMP_LOW   = 2'h2;
  localparam logic [1:0] CMP_EQUAL = 2'h3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ      = 250;
  localparam int FETCH_US     = 90;
  localparam int EXEC_NOBR_US = 75;
  localparam int EXEC_BR_US   = 95;
  localparam int FETCH_CYC     = FETCH_US * CLK_MHZ;
  localparam int EXEC_NOBR_CYC = EXEC_NOBR_US * CLK_MHZ;
  localparam int EXEC_BR_CYC   = EXEC_BR_US * CLK_MHZ;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_ST = 8'h08;
  localparam logic [7:0] OFS_IRQ_MK = 8'h0C;
  localparam logic [7:0] OFS_LASTPC = 8'h10;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int ST_BUSY_BIT     = 0;
  localparam int ST_TAKEN_BIT    = 1;
  localparam int IRQ_W           = 3;
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_NOCMP_BIT   = 1;
  localparam int IRQ_OVF_BIT     = 2;
  localparam logic CTRL_RESET    = 1'b1;

endpackage

// *** src/conditional_branch_unit.sv ***
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module conditional_branch_unit #(
  parameter int FETCH_CYCLES     = branch_unit_pkg::FETCH_CYC,
  parameter int EXEC_NOBR_CYCLES = branch_unit_pkg::EXEC_NOBR_CYC,
  parameter int EXEC_BR_CYCLES   = branch_unit_pkg::EXEC_BR_CYC
) (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [branch_unit_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Fetch sequencer request
  input  wire logic                           exec_start,
  input  wire branch_unit_pkg::instr_t        instruction_reg,
  // Machine state
  input  wire branch_unit_pkg::word_t         accumulator_reg,
  input  wire branch_unit_pkg::word_t         extension_reg,
  input  wire logic [branch_unit_pkg::ADDR_W-1:0] index_reg,
  input  wire logic [branch_unit_pkg::ADDR_W-1:0] program_counter,
  input  wire logic                           repeat_flag,
  input  wire logic [1:0]                     compare_flag,
  // Results to the sequencer
  output logic                                exec_busy,
  output logic                                exec_done,
  output logic                                clear_operand_addr,
  output branch_unit_pkg::branch_result_t     result,
  // Interrupt
  output logic                                irq
);
  import branch_unit_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Four-digit decimal add, carry out of the top digit dropped
  function automatic logic [ADDR_W-1:0] bcd_add4(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] b
  );
    logic [4:0] s;
    logic       c;
    s = 5'h00;
    c = 1'b0;
    bcd_add4 = '0;
    for (int i = 0; i < 4; i++) begin
      s = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c};
      if (s > 5'h09) begin
        s = s + 5'h06;
        c = 1'b1;
      end else begin
        c = 1'b0;
      end
      bcd_add4[i*4 +: 4] = s[3:0];
    end
  endfunction

  // Digit at a position, 0 is the sign, 10 the rightmost
  function automatic logic [3:0] word_digit(
    input word_t      w,
    input logic [3:0] pos
  );
    logic [5:0] idx;
    idx = 6'(7'h28 - {1'b0, pos, 2'b00});
    word_digit = w[idx +: 4];
  endfunction

  // ****************************************************************
  // State machine and working registers
  // ****************************************************************
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,                      // Waiting for a request
    S_FIELD = 4'b0010,                      // Digit-serial compare
    S_TIME  = 4'b0100,                      // Instruction timing
    S_DONE  = 4'b1000                       // Answer to sequencer
  } state_t;

  state_t             state_reg;            // Current state
  logic               enable_reg;           // Software run enable
  logic [IRQ_W-1:0]   irq_status_reg;       // Sticky events
  logic [IRQ_W-1:0]   irq_mask_reg;         // Interrupt mask
  logic [ADDR_W-1:0]  target_reg;           // Modified address
  logic [ADDR_W-1:0]  seq_reg;              // Next sequential address
  word_t              operand_reg;          // Selected field source
  logic [3:0]         pos_reg;              // Digit being compared
  logic [3:0]         len_reg;              // Remaining length
  logic               pos_out_reg;          // Sign digit passed
  logic               odd_reg;              // Use high basis digit
  logic               miss_reg;             // Some digit differed
  logic [3:0]         basis_lo_reg;         // Basis low digit
  logic [3:0]         basis_hi_reg;         // Basis high digit
  logic               taken_reg;            // Branch decision
  logic               nocmp_reg;            // No comparison alarm
  logic               ovf_reg;              // Field overflow alarm
  logic [CNT_W-1:0]   cnt_reg;              // Cycles since request
  logic [CNT_W-1:0]   total_cyc;            // Fetch plus execute
  logic               take_req;             // Request accepted
  logic [ADDR_W-1:0]  target_next;          // Address for this request
  logic               quick_taken;          // Decision of flag branches
  logic               quick_nocmp;          // Flag branch alarm
  logic               is_field;             // Field branch requested
  logic               digit_eq;             // Current digit matches
  logic               field_end;            // Field walk complete
  logic               done_evt;             // Answer cycle
  logic               apb_wr;               // Write access phase
  logic               apb_setup;            // Setup phase

  assign take_req = exec_start && enable_reg && (state_reg == S_IDLE);
  assign is_field = (instruction_reg.opcode == OP_FIELD_A) ||
                    (instruction_reg.opcode == OP_FIELD_R);
  assign done_evt = (state_reg == S_DONE);

  // ****************************************************************
  // Address forming
  // ****************************************************************

  always_comb begin
    if (instruction_reg.sign_digit[0]) begin
      target_next = bcd_add4(instruction_reg.address, index_reg);
    end else begin
      target_next = instruction_reg.address;
    end
  end

  // ****************************************************************
  // Decision for the flag branches
  // ****************************************************************

  // Flags are only read here, never written back
  // flags left untouched
  always_comb begin
    quick_taken = 1'b0;
    quick_nocmp = 1'b0;
    unique case (instruction_reg.opcode)
      OP_REPEAT: quick_taken = repeat_flag;
      OP_SIGN: quick_taken = (word_digit(accumulator_reg, 4'h0) ==
                              instruction_reg.basis_lo);
      OP_HIGHLOW: begin
        if (compare_flag == CMP_NONE) begin
          quick_nocmp = 1'b1;
        end else if (instruction_reg.basis_lo == VAR_ONE) begin
          quick_taken = (compare_flag == CMP_LOW);
        end else begin
          quick_taken = (compare_flag == CMP_HIGH);
        end
      end
      OP_EQUAL: begin
        if (compare_flag == CMP_NONE) begin
          quick_nocmp = 1'b1;
        end else if (instruction_reg.basis_lo == VAR_ONE) begin
          quick_taken = (compare_flag != CMP_EQUAL);
        end else begin
          quick_taken = (compare_flag == CMP_EQUAL);
        end
      end
      // Field codes decide elsewhere, foreign codes never branch
      default: quick_taken = 1'b0;
    endcase
  end

  // ****************************************************************
  // Field compare datapath
  // ****************************************************************

  assign digit_eq = (word_digit(operand_reg, pos_reg) ==
                     (odd_reg ? basis_hi_reg : basis_lo_reg));
  assign field_end = (len_reg == 4'h0) || pos_out_reg;

  // Request capture and field walk
  always_ff @(posedge clk) begin
    if (rst) begin
      target_reg   <= '0;
      seq_reg      <= '0;
      operand_reg  <= '0;
      pos_reg      <= 4'h0;
      len_reg      <= 4'h0;
      pos_out_reg  <= 1'b0;
      odd_reg      <= 1'b0;
      miss_reg     <= 1'b0;
      basis_lo_reg <= 4'h0;
      basis_hi_reg <= 4'h0;
    end else if (take_req) begin
      target_reg   <= target_next;
      seq_reg      <= bcd_add4(program_counter, 16'h0001);
      operand_reg  <= (instruction_reg.opcode == OP_FIELD_R) ?
                      extension_reg : accumulator_reg;
      pos_reg      <= (instruction_reg.pos_digit == 4'h0) ?
                      LAST_POS : instruction_reg.pos_digit;
      len_reg      <= (instruction_reg.len_digit == 4'h0) ?
                      FULL_LEN : instruction_reg.len_digit;
      pos_out_reg  <= 1'b0;
      odd_reg      <= 1'b0;
      miss_reg     <= 1'b0;
      basis_lo_reg <= instruction_reg.basis_lo;
      basis_hi_reg <= instruction_reg.basis_hi;
    end else if (state_reg == S_FIELD && !field_end) begin
      // One digit per cycle, moving toward the sign
      if (!digit_eq) begin
        miss_reg <= 1'b1;
      end
      len_reg <= len_reg - 4'h1;
      odd_reg <= ~odd_reg;
      if (pos_reg == 4'h0) begin
        pos_out_reg <= 1'b1;
      end else begin
        pos_reg <= pos_reg - 4'h1;
      end
    end
  end

  // ****************************************************************
  // Decision and alarm registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      taken_reg <= 1'b0;
      nocmp_reg <= 1'b0;
      ovf_reg   <= 1'b0;
    end else if (take_req) begin
      taken_reg <= quick_taken;
      nocmp_reg <= quick_nocmp;
      ovf_reg   <= 1'b0;
    end else if (state_reg == S_FIELD && field_end) begin
      taken_reg <= !miss_reg;
      ovf_reg   <= (len_reg != 4'h0);
    end
  end

  // ****************************************************************
  // Sequencing and timing
  // ****************************************************************

  assign total_cyc = taken_reg ?
                     CNT_W'(FETCH_CYCLES + EXEC_BR_CYCLES - 1) :
                     CNT_W'(FETCH_CYCLES + EXEC_NOBR_CYCLES - 1);

  // Cycle counter, restarted on each request
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (take_req) begin
      cnt_reg <= CNT_W'(1);
    end else if (state_reg != S_IDLE && cnt_reg != total_cyc) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // Main state machine
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (take_req) begin
            state_reg <= is_field ? S_FIELD : S_TIME;
          end
        end
        S_FIELD: begin
          if (field_end) begin
            state_reg <= S_TIME;
          end
        end
        S_TIME: begin
          if (cnt_reg >= total_cyc) begin
            state_reg <= S_DONE;
          end
        end
        S_DONE: state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Results to the sequencer
  // ****************************************************************

  // Result and done strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      result             <= '0;
      exec_done          <= 1'b0;
      clear_operand_addr <= 1'b0;
    end else begin
      exec_done          <= (state_reg == S_TIME) &&
                            (cnt_reg >= total_cyc);
      clear_operand_addr <= (state_reg == S_TIME) &&
                            (cnt_reg >= total_cyc);
      if (state_reg == S_TIME && cnt_reg >= total_cyc) begin
        result.next_pc <= (taken_reg && !nocmp_reg) ?
                          target_reg : seq_reg;
        result.taken                <= taken_reg && !nocmp_reg;
        result.alarm_no_compare     <= nocmp_reg;
        result.alarm_field_overflow <= ovf_reg;
      end
    end
  end

  assign exec_busy = (state_reg != S_IDLE);

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign apb_wr    = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign pready    = 1'b1;

  // Control register
  always_ff @(posedge clk) begin
    if (rst) begin
      enable_reg <= CTRL_RESET;
    end else if (apb_wr && paddr == OFS_CTRL) begin
      enable_reg <= pwdata[CTRL_ENABLE_BIT];
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_reg <= '0;
    end else if (apb_wr && paddr == OFS_IRQ_MK) begin
      irq_mask_reg <= pwdata[IRQ_W-1:0];
    end
  end

  // Sticky status, a new event wins over a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_reg <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if (done_evt && (i == IRQ_DONE_BIT ||
            (i == IRQ_NOCMP_BIT && result.alarm_no_compare) ||
            (i == IRQ_OVF_BIT && result.alarm_field_overflow))) begin
          irq_status_reg[i] <= 1'b1;
        end else if (apb_wr && paddr == OFS_IRQ_ST && pwdata[i]) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // Read data captured in the setup phase
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= 1'b0;
      prdata  <= '0;
      unique case (paddr)
        OFS_CTRL:   prdata[CTRL_ENABLE_BIT] <= enable_reg;
        OFS_STATUS: begin
          prdata[ST_BUSY_BIT]  <= exec_busy;
          prdata[ST_TAKEN_BIT] <= result.taken;
        end
        OFS_IRQ_ST: prdata[IRQ_W-1:0] <= irq_status_reg;
        OFS_IRQ_MK: prdata[IRQ_W-1:0] <= irq_mask_reg;
        OFS_LASTPC: prdata[ADDR_W-1:0] <= result.next_pc;
        // Unmapped address answers with an error
        default:    pslverr <= 1'b1;
      endcase
    end
  end

endmodule // conditional_branch_unit

// *** bench/branch_unit_props.sv ***
`timescale 1ns/1ns
// ********************************************
// Sequencer-side checks of the branch unit
// ********************************************
module branch_unit_props #(
  parameter int FETCH_CYCLES     = 20,
  parameter int EXEC_NOBR_CYCLES = 5,
  parameter int EXEC_BR_CYCLES   = 8
) (
  // Clock and reset
  input wire logic                            clk,
  input wire logic                            rst,
  // Sequencer side
  input wire logic                            exec_start,
  input wire logic                            exec_busy,
  input wire logic                            exec_done,
  input wire logic                            clear_operand_addr,
  input wire branch_unit_pkg::branch_result_t result
);
  import branch_unit_pkg::*;
  int busy_cnt; // Busy cycles seen so far
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Count busy cycles of the running operation
  always_ff @(posedge clk) begin
    if (rst || !exec_busy) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  done_timing_a: assert property (exec_done |-> busy_cnt == (result.taken ?
    FETCH_CYCLES + EXEC_BR_CYCLES - 1 : FETCH_CYCLES + EXEC_NOBR_CYCLES - 1))
    else $error("done at wrong cycle");
  busy_from_start_a: assert property ($rose(exec_busy) |-> $past(exec_start))
    else $error("busy without start");
  done_single_a: assert property (exec_done |=> !exec_done && !exec_busy)
    else $error("done not single");
  busy_hold_a: assert property (exec_busy && !exec_done |=> exec_busy)
    else $error("busy dropped early");
  clear_operand_a: assert property (clear_operand_addr == exec_done)
    else $error("operand clear apart from done");
  nocmp_seq_a: assert property (exec_done && result.alarm_no_compare
    |-> !result.taken) else $error("no-compare alarm with branch");
  result_hold_a: assert property (!exec_done |-> $stable(result))
    else $error("result moved without done");
  alarm_kind_a: assert property (exec_done |-> !(result.alarm_no_compare
    && result.alarm_field_overflow)) else $error("both alarms");
  // Main scenarios
  cover property (exec_done && result.taken);
  cover property (exec_done && result.alarm_no_compare);
  cover property (exec_done && result.alarm_field_overflow);
endmodule // branch_unit_props

bind conditional_branch_unit branch_unit_props #(
  .FETCH_CYCLES(FETCH_CYCLES),
  .EXEC_NOBR_CYCLES(EXEC_NOBR_CYCLES),
  .EXEC_BR_CYCLES(EXEC_BR_CYCLES)
) branch_unit_props_inst (.clk(clk), .rst(rst), .exec_start(exec_start),
  .exec_busy(exec_busy), .exec_done(exec_done),
  .clear_operand_addr(clear_operand_addr), .result(result));

// *** bench/conditional_branch_unit_tb.sv ***
`timescale 1ns/1ns
// ********************************************
// Branch unit testbench
// ********************************************
module conditional_branch_unit_tb;
  import branch_unit_pkg::*;
  localparam logic [15:0] T = 16'h2000; // Target field
  localparam logic [15:0] S = 16'h0101; // Next in sequence
  logic clk, rst, psel, penable, pwrite, exec_start, repeat_flag;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, exec_busy, exec_done, clr, irq;
  instr_t instruction_reg;
  word_t acc, ext;
  logic [1:0] compare_flag;
  branch_result_t result;
  int fails, n_tests;
  conditional_branch_unit #(.FETCH_CYCLES(20), .EXEC_NOBR_CYCLES(5),
    .EXEC_BR_CYCLES(8)) conditional_branch_unit_inst (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exec_start(exec_start), .instruction_reg(instruction_reg),
    .accumulator_reg(acc), .extension_reg(ext), .index_reg(16'h0345),
    .program_counter(16'h0100), .repeat_flag(repeat_flag),
    .compare_flag(compare_flag), .exec_busy(exec_busy),
    .exec_done(exec_done), .clear_operand_addr(clr), .result(result),
    .irq(irq));
  // Clock, 4 ns period
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // Compare tasks
  task chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task chkr(input branch_result_t g, e);
    chk({13'h0, g}, {13'h0, e});
  endtask
  // APB transfer, waits for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [32:0] e);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    if (!w) chk({prdata[30:0], pslverr}, {e[30:0], e[32]});
    psel <= 0;
    penable <= 0;
  endtask
  // One branch execution and its result
  task ex(input logic [7:0] op, input logic [3:0] sg, ps, ln, bh, bl,
          input word_t a, input logic rp, input logic [1:0] cf,
          input logic [15:0] ad, e, input logic [2:0] fl);
    int i;
    @(posedge clk);
    exec_start <= 1;
    instruction_reg <= '{sg, ps, ln, bh, bl, op, ad};
    acc <= (op == OP_FIELD_R) ? ~a : a;
    ext <= (op == OP_FIELD_R) ? a : ~a;
    repeat_flag <= rp;
    compare_flag <= cf;
    @(posedge clk);
    exec_start <= 0;
    for (i = 0; i < 100 && exec_done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chkr(result, '{e, fl[2], fl[1], fl[0]});
    chk(i, fl[2] ? 32'h1B : 32'h18);
    chk(clr, 32'h1);
  endtask
  // Verdict and end of run
  task test_done;
    $display("Mismatches %0d comparisons %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done;
  end
  // Main sequence
  initial begin
    {rst, psel, penable, pwrite, exec_start, repeat_flag} = 6'h20;
    {paddr, pwdata, acc, ext, compare_flag} = '0;
    instruction_reg = '0;
    fails = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    rst <= 0;
    apb(0, OFS_CTRL, 0, 33'h1);
    apb(0, OFS_IRQ_MK, 0, 33'h0);
    apb(0, 8'h20, 0, 33'h100000000);
    ex(OP_REPEAT, 0, 0, 0, 0, 0, 0, 1, CMP_NONE, T, T, 4);
    apb(0, OFS_STATUS, 0, 33'h2);
    apb(0, OFS_LASTPC, 0, {17'h0, T});
    apb(0, OFS_IRQ_ST, 0, 33'h1);
    chk(irq, 0);
    apb(1, OFS_IRQ_MK, 1, 0);
    @(posedge clk);
    chk(irq, 1);
    apb(1, OFS_IRQ_ST, 1, 0);
    @(posedge clk);
    chk(irq, 0);
    ex(OP_REPEAT, 0, 0, 0, 0, 0, 0, 0, CMP_NONE, T, S, 0);
    ex(OP_REPEAT, 1, 0, 0, 0, 0, 0, 1, 0, 16'h0678, 16'h1023, 4);
    ex(OP_REPEAT, 3, 0, 0, 0, 0, 0, 1, 0, 16'h9990, 16'h0335, 4);
    ex(OP_REPEAT, 2, 0, 0, 0, 0, 0, 1, 0, T, T, 4);
    ex(OP_SIGN, 0, 0, 0, 0, 5, 44'h50000000000, 0, 0, T, T, 4);
    ex(OP_SIGN, 0, 0, 0, 0, 4, 44'h50000000000, 0, 0, T, S, 0);
    ex(OP_HIGHLOW, 0, 0, 0, 0, 0, 0, 0, CMP_HIGH, T, T, 4);
    ex(OP_HIGHLOW, 0, 0, 0, 0, 0, 0, 0, CMP_LOW, T, S, 0);
    ex(OP_HIGHLOW, 0, 0, 0, 0, 0, 0, 0, CMP_EQUAL, T, S, 0);
    ex(OP_HIGHLOW, 0, 0, 0, 0, 1, 0, 0, CMP_LOW, T, T, 4);
    ex(OP_HIGHLOW, 0, 0, 0, 0, 1, 0, 0, CMP_HIGH, T, S, 0);
    ex(OP_HIGHLOW, 0, 0, 0, 0, 7, 0, 0, CMP_HIGH, T, T, 4);
    ex(OP_EQUAL, 0, 0, 0, 0, 0, 0, 0, CMP_EQUAL, T, T, 4);
    ex(OP_EQUAL, 0, 0, 0, 0, 0, 0, 0, CMP_HIGH, T, S, 0);
    ex(OP_EQUAL, 0, 0, 0, 0, 1, 0, 0, CMP_HIGH, T, T, 4);
    ex(OP_EQUAL, 0, 0, 0, 0, 1, 0, 0, CMP_LOW, T, T, 4);
    ex(OP_EQUAL, 0, 0, 0, 0, 1, 0, 0, CMP_EQUAL, T, S, 0);
    ex(OP_EQUAL, 0, 0, 0, 0, 3, 0, 0, CMP_EQUAL, T, T, 4);
    ex(OP_HIGHLOW, 0, 0, 0, 0, 0, 0, 0, CMP_NONE, T, S, 2);
    apb(0, OFS_IRQ_ST, 0, 33'h3);
    ex(OP_EQUAL, 0, 0, 0, 0, 1, 0, 0, CMP_NONE, T, S, 2);
    ex(OP_FIELD_A, 0, 0, 4, 2, 1, 44'h2121, 0, 0, T, T, 4);
    ex(OP_FIELD_A, 0, 0, 4, 2, 1, 44'h1121, 0, 0, T, S, 0);
    ex(OP_FIELD_R, 0, 0, 4, 2, 1, 44'h2121, 0, 0, T, T, 4);
    ex(OP_FIELD_R, 0, 0, 4, 2, 1, 44'h2122, 0, 0, T, S, 0);
    ex(OP_FIELD_A, 0, 7, 2, 3, 4, 44'h34000, 0, 0, T, T, 4);
    ex(OP_FIELD_A, 0, 0, 0, 2, 1, 44'h2121212121, 0, 0, T, T, 4);
    ex(OP_FIELD_A, 0, 2, 5, 2, 1, 44'h9900000000, 0, 0, T, S, 1);
    apb(0, OFS_IRQ_ST, 0, 33'h7);
    apb(1, OFS_CTRL, 0, 0);
    @(posedge clk);
    exec_start <= 1;
    @(posedge clk);
    exec_start <= 0;
    repeat (3) @(posedge clk);
    chk(exec_busy, 0);
    apb(1, OFS_CTRL, 1, 0);
    test_done;
  end
endmodule // conditional_branch_unit_tb
